// ===== pifl_irq_flags.sv
// Top of the peripheral interrupt flag and enable block with its APB slave.
//
// Register access over APB was decided locally.
module pifl_irq_flags (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [pifl_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    input  wire logic [3:0]                pstrb,
    output logic                           pready,
    output logic                           pslverr,
    output logic [31:0]                    prdata,
    input  wire logic                      conv_done_evt,
    input  wire logic                      serial_done_evt,
    input  wire logic                      capture_evt,
    input  wire logic                      compare_evt,
    input  wire logic                      period_match_evt,
    input  wire logic                      overflow_evt,
    input  wire logic                      nvm_write_done_evt,
    input  wire pifl_pkg::pifl_ccmode_t    capcomp_mode,
    output logic                           irq
);
    import pifl_pkg::*;

    // Whole registered state of the top: bus answer, core enables and interrupt line.
    // Every output leaves this register, so none can glitch.
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        global_irq_enable;
        logic        periph_master_enable;
        logic        irq;
    } pifl_top_state_t;

    pifl_top_state_t st_q;  // Registered state.
    pifl_top_state_t st_d;  // Next state.

    // Bus phase decode.
    logic setup_ph;  // Setup cycle of a transfer.
    logic fire;      // Edge at which the transfer completes.
    logic wr_fire;   // Completing write.

    // Address hits, decoded from the held address.
    logic hit_one;   // First flag register.
    logic hit_two;   // Second flag register.
    logic hit_en2;   // Second enable register.
    logic hit_ctrl;  // Core control register.
    logic hit_stat;  // Interrupt status, read-only.
    logic hit_clr;   // Interrupt clear, write-only.
    logic hit_ien;   // Interrupt enable.
    logic hit_any;   // Any mapped register.

    // Per-lane write strobes for the two low bytes.
    logic wr_lane0;  // Byte 0 is written.
    logic wr_lane1;  // Byte 1 is written.

    // Event inputs routed to flag positions.
    logic [7:0] set_one;  // Set requests of the first flag register.
    logic       set_two;  // Set request of the write-done flag.

    // Software write and clear requests for both flag registers.
    logic       wr_one;   // Direct write of the first flag register.
    logic [7:0] clr_one;  // Clear by the interrupt clear register.
    logic       wr_two;   // Direct write of the second flag register.
    logic       clr_two;  // Clear of the write-done flag.

    // Current flag and enable values.
    logic [7:0] periph_irq_flags_one;    // First flag register, unimplemented bits zero.
    logic [7:0] periph_irq_flags_two;    // Second flag register.
    logic [7:0] periph_irq_enables_one;  // Enables for the first flag register.
    logic [7:0] periph_irq_enables_two;  // Second enable register.
    logic       nvm_flag;                // Write-done flag.
    logic       nvm_en;                  // Write-complete interrupt enable.

    // Enable write requests.
    logic       wr_en_one;     // Low byte of the interrupt enable register.
    logic       wr_en_two;     // Write-complete enable from either register.
    logic       en_two_val;    // Value written into that enable.

    // Combined request and read data.
    logic        pending;  // Any enabled flag set.
    logic [31:0] rd_val;   // Read value for the held address.

    // A transfer is answered one cycle after setup, so pready stands for exactly one access cycle.
    // No wait state is ever inserted.
    assign setup_ph = psel & ~penable;
    assign fire     = psel & penable & st_q.pready;
    assign wr_fire  = fire & pwrite;
    assign wr_lane0 = wr_fire & pstrb[0];
    assign wr_lane1 = wr_fire & pstrb[1];

    // Address decode as a priority chain; only one can match.
    always_comb begin
        hit_one  = 1'b0;
        hit_two  = 1'b0;
        hit_en2  = 1'b0;
        hit_ctrl = 1'b0;
        hit_stat = 1'b0;
        hit_clr  = 1'b0;
        hit_ien  = 1'b0;
        if (paddr == ADDR_FLAGS_ONE) begin
            hit_one = 1'b1;
        end else if (paddr == ADDR_FLAGS_TWO) begin
            hit_two = 1'b1;
        end else if (paddr == ADDR_ENABLES_TWO) begin
            hit_en2 = 1'b1;
        end else if (paddr == ADDR_CORE_CTRL) begin
            hit_ctrl = 1'b1;
        end else if (paddr == ADDR_IRQ_STATUS) begin
            hit_stat = 1'b1;
        end else if (paddr == ADDR_IRQ_CLEAR) begin
            hit_clr = 1'b1;
        end else if (paddr == ADDR_IRQ_ENABLE) begin
            hit_ien = 1'b1;
        end
    end

    // Unmapped addresses answer with an error and change nothing.
    assign hit_any = hit_one | hit_two | hit_en2 | hit_ctrl | hit_stat | hit_clr | hit_ien;

    // Route peripheral events to their flags; enables are not looked at here.
    // An event held high keeps setting its flag every cycle.
    always_comb begin
        set_one                   = RST_BYTE;
        set_one[BIT_CONV_DONE]    = conv_done_evt;
        set_one[BIT_SERIAL]       = serial_done_evt;
        set_one[BIT_PERIOD_MATCH] = period_match_evt;
        set_one[BIT_OVERFLOW]     = overflow_evt;
        // The flag follows the mode; in off and PWM mode nothing sets it.
        case (capcomp_mode)
            PIFL_CC_CAPTURE: begin
                set_one[BIT_CAPCOMP] = capture_evt;
            end
            PIFL_CC_COMPARE: begin
                set_one[BIT_CAPCOMP] = compare_evt;
            end
            default: begin
                set_one[BIT_CAPCOMP] = 1'b0;
            end
        endcase
        set_two = nvm_write_done_evt;
    end

    // Software requests: direct writes, and write-one-to-clear through the clear register.
    // A zero bit in the clear word leaves its flag alone.
    assign wr_one  = wr_lane0 & hit_one;
    assign clr_one = (wr_lane0 & hit_clr) ? pwdata[7:0] : RST_BYTE;
    assign wr_two  = wr_lane0 & hit_two;
    assign clr_two = wr_lane1 & hit_clr & pwdata[LANE_TWO + BIT_NVM];

    // One sticky cell per implemented flag; unimplemented positions are constant zero.
    // Hardware never clears a flag; only software does.
    for (genvar i = 0; i < 8; i++) begin : g_flag_one
        if (MASK_ONE[i]) begin : g_impl
            pifl_flag_bit u_flag (
                .pclk    (pclk),
                .presetn (presetn),
                .set_evt (set_one[i]),
                .sw_wr   (wr_one),
                .sw_val  (pwdata[i]),
                .sw_clr  (clr_one[i]),
                .flag    (periph_irq_flags_one[i])
            );
        end else begin : g_none
            assign periph_irq_flags_one[i] = 1'b0;
        end
    end

    // Enables for the first flag register, written through the interrupt enable register.
    // Unimplemented positions stay zero and ignore writes.
    assign wr_en_one = wr_lane0 & hit_ien;

    for (genvar i = 0; i < 8; i++) begin : g_en_one
        if (MASK_ONE[i]) begin : g_impl
            pifl_enable_bit u_en (
                .pclk    (pclk),
                .presetn (presetn),
                .sw_wr   (wr_en_one),
                .sw_val  (pwdata[i]),
                .en      (periph_irq_enables_one[i])
            );
        end else begin : g_none
            assign periph_irq_enables_one[i] = 1'b0;
        end
    end

    // The write-done flag; the rest of the second flag register is constant zero.
    always_comb begin
        periph_irq_flags_two   = RST_BYTE;
        periph_irq_enables_two = RST_BYTE;
        periph_irq_flags_two[BIT_NVM]   = nvm_flag;
        periph_irq_enables_two[BIT_NVM] = nvm_en;
    end

    // The write-done cell sets even while its enable is off.
    pifl_flag_bit u_nvm_flag (
        .pclk    (pclk),
        .presetn (presetn),
        .set_evt (set_two),
        .sw_wr   (wr_two),
        .sw_val  (pwdata[BIT_NVM]),
        .sw_clr  (clr_two),
        .flag    (nvm_flag)
    );

    // The write-complete enable is reachable at its own register and aliased in the enable layout.
    // The decode is one-hot, so only one of the two paths writes it.
    assign wr_en_two  = (wr_lane0 & hit_en2) | (wr_lane1 & hit_ien);
    assign en_two_val = hit_en2 ? pwdata[BIT_NVM] : pwdata[LANE_TWO + BIT_NVM];

    pifl_enable_bit u_nvm_en (
        .pclk    (pclk),
        .presetn (presetn),
        .sw_wr   (wr_en_two),
        .sw_val  (en_two_val),
        .en      (nvm_en)
    );

    // A flag only requests while its own enable is set; stale flags fire at once when enabled.
    // Software must clear stale flags first; nothing here filters them.
    assign pending = |(periph_irq_flags_one & periph_irq_enables_one)
                   | (nvm_flag & nvm_en);

    // Read multiplexer; write-only and unmapped addresses read zero.
    // Byte lanes two and three always read zero.
    always_comb begin
        rd_val = RST_WORD;
        if (hit_one) begin
            rd_val[7:0] = periph_irq_flags_one;
        end else if (hit_two) begin
            rd_val[7:0] = periph_irq_flags_two;
        end else if (hit_en2) begin
            rd_val[7:0] = periph_irq_enables_two;
        end else if (hit_ctrl) begin
            rd_val[BIT_GLOBAL_EN] = st_q.global_irq_enable;
            rd_val[BIT_MASTER_EN] = st_q.periph_master_enable;
        end else if (hit_stat) begin
            rd_val[7:0]                  = periph_irq_flags_one;
            rd_val[LANE_TWO+7:LANE_TWO]  = periph_irq_flags_two;
        end else if (hit_ien) begin
            rd_val[7:0]                  = periph_irq_enables_one;
            rd_val[LANE_TWO+7:LANE_TWO]  = periph_irq_enables_two;
        end
    end

    // Bus answer, core enables and the interrupt line.
    always_comb begin
        st_d = st_q;
        // Read data is caught at setup and held through the access cycle.
        if (setup_ph) begin
            st_d.pready  = 1'b1;
            st_d.pslverr = ~hit_any;
            st_d.prdata  = pwrite ? RST_WORD : rd_val;
        end else if (fire) begin
            st_d.pready  = 1'b0;
            st_d.pslverr = 1'b0;
        end
        // Core enables live in byte 0 of the control register.
        // Writes to other bits of that byte are dropped.
        if (wr_lane0 && hit_ctrl) begin
            st_d.global_irq_enable    = pwdata[BIT_GLOBAL_EN];
            st_d.periph_master_enable = pwdata[BIT_MASTER_EN];
        end
        // Registered so the output is glitch-free; it lags a flag by one cycle.
        st_d.irq = st_q.global_irq_enable & st_q.periph_master_enable & pending;
    end

    // State register, cleared at reset.
    // The flag and enable cells reset themselves.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register.
    // Plain wires, so interface timing is that of the register.
    assign pready  = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign prdata  = st_q.prdata;
    assign irq     = st_q.irq;

endmodule : pifl_irq_flags

// ===== pifl_pkg.sv
// Package with register map, bit positions and modes of the peripheral interrupt flag block.
package pifl_pkg;

    // Byte address width of the register slave.
    localparam int ADDR_W = 12;

    // Register indices; the byte address is four times the index.
    localparam logic [ADDR_W-1:0] IDX_FLAGS_ONE   = 12'h00C;
    localparam logic [ADDR_W-1:0] IDX_FLAGS_TWO   = 12'h00D;
    localparam logic [ADDR_W-1:0] IDX_ENABLES_TWO = 12'h08D;
    localparam logic [ADDR_W-1:0] IDX_CORE_CTRL   = 12'h0A0;
    localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS  = 12'h0A1;
    localparam logic [ADDR_W-1:0] IDX_IRQ_CLEAR   = 12'h0A2;
    localparam logic [ADDR_W-1:0] IDX_IRQ_ENABLE  = 12'h0A3;

    // Byte addresses derived from the indices.
    localparam logic [ADDR_W-1:0] ADDR_FLAGS_ONE   = IDX_FLAGS_ONE << 2;
    localparam logic [ADDR_W-1:0] ADDR_FLAGS_TWO   = IDX_FLAGS_TWO << 2;
    localparam logic [ADDR_W-1:0] ADDR_ENABLES_TWO = IDX_ENABLES_TWO << 2;
    localparam logic [ADDR_W-1:0] ADDR_CORE_CTRL   = IDX_CORE_CTRL << 2;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS  = IDX_IRQ_STATUS << 2;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR   = IDX_IRQ_CLEAR << 2;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE  = IDX_IRQ_ENABLE << 2;

    // Bit positions in the first flag register (and its enables).
    localparam int BIT_CONV_DONE    = 6;
    localparam int BIT_SERIAL       = 3;
    localparam int BIT_CAPCOMP      = 2;
    localparam int BIT_PERIOD_MATCH = 1;
    localparam int BIT_OVERFLOW     = 0;

    // Bit position of the write-complete flag and enable.
    localparam int BIT_NVM = 4;

    // Bit positions in the core control register.
    localparam int BIT_GLOBAL_EN = 7;
    localparam int BIT_MASTER_EN = 6;

    // Bit offset of the second flag byte (byte lane 1) in the status layout.
    localparam int LANE_TWO = 8;

    // Implemented bit masks.
    localparam logic [7:0] MASK_ONE  = 8'h4F;
    localparam logic [7:0] MASK_TWO  = 8'h10;
    localparam logic [7:0] MASK_CTRL = 8'hC0;

    // Reset value of every register.
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // Operating mode reported by the capture/compare unit.
    typedef enum logic [1:0] {
        PIFL_CC_OFF     = 2'b00,
        PIFL_CC_CAPTURE = 2'b01,
        PIFL_CC_COMPARE = 2'b10,
        PIFL_CC_PWM     = 2'b11
    } pifl_ccmode_t;

endpackage : pifl_pkg

// ===== pifl_flag_bit.sv
// Sticky interrupt flag bit with software write and clear.
module pifl_flag_bit (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic set_evt,
    input  wire logic sw_wr,
    input  wire logic sw_val,
    input  wire logic sw_clr,
    output logic      flag
);
    import pifl_pkg::*;

    // Whole state of the cell.
    typedef struct packed {
        logic flag;
    } pifl_flag_state_t;

    pifl_flag_state_t st_q;  // Registered state.
    pifl_flag_state_t st_d;  // Next state.

    // The event wins over any software clear in the same cycle, so no event is lost.
    always_comb begin
        st_d = st_q;
        if (set_evt) begin
            st_d.flag = 1'b1;
        end else if (sw_clr) begin
            st_d.flag = 1'b0;
        end else if (sw_wr) begin
            st_d.flag = sw_val;
        end
    end

    // State register, cleared at reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign flag = st_q.flag;
endmodule : pifl_flag_bit

// ===== pifl_enable_bit.sv
// Software read/write enable bit.
module pifl_enable_bit (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic sw_wr,
    input  wire logic sw_val,
    output logic      en
);
    import pifl_pkg::*;

    // Whole state of the cell.
    typedef struct packed {
        logic en;
    } pifl_en_state_t;

    pifl_en_state_t st_q;  // Registered state.
    pifl_en_state_t st_d;  // Next state.

    // Load the new value on a software write.
    always_comb begin
        st_d = st_q;
        if (sw_wr) begin
            st_d.en = sw_val;
        end
    end

    // State register, cleared at reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign en = st_q.en;
endmodule : pifl_enable_bit

// ===== pifl_irq_flags_chk.sv
// Port-level assertions for the peripheral interrupt flag block.
module pifl_irq_flags_chk (
    input wire logic                        pclk,
    input wire logic                        presetn,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic [pifl_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0]                 pwdata,
    input wire logic [3:0]                  pstrb,
    input wire logic                        pready,
    input wire logic                        pslverr,
    input wire logic [31:0]                 prdata,
    input wire logic                        conv_done_evt,
    input wire logic                        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    import pifl_pkg::*;

    // One clock domain, so clocking and reset are stated once.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // High when the address hits a register of the map.
    logic mapped;
    assign mapped = paddr inside {ADDR_FLAGS_ONE, ADDR_FLAGS_TWO, ADDR_ENABLES_TWO, ADDR_CORE_CTRL,
                                  ADDR_IRQ_STATUS, ADDR_IRQ_CLEAR, ADDR_IRQ_ENABLE};

    // Setup cycle of a read at one register.
    sequence s_rd_setup(logic [ADDR_W-1:0] a);
        psel && !penable && !pwrite && paddr == a;
    endsequence

    // Completing access cycle of a write that turns the master enable off.
    sequence s_master_off;
        psel && penable && pready && pwrite && paddr == ADDR_CORE_CTRL && pstrb[0] && !pwdata[BIT_MASTER_EN];
    endsequence

    chk_ready_one_pulse: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    chk_setup_gets_ready: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    chk_unmapped_error: assert property (psel && penable && pready |-> pslverr == !mapped)
        else $error("error response does not match the map");
    chk_flags_one_mask: assert property (s_rd_setup(ADDR_FLAGS_ONE) |=> (prdata & ~{24'h0, MASK_ONE}) == 32'h0)
        else $error("unimplemented flag bits read nonzero");
    chk_enables_two_mask: assert property (s_rd_setup(ADDR_ENABLES_TWO) |=> (prdata & ~32'h10) == 32'h0)
        else $error("unimplemented enable bits read nonzero");
    chk_flags_two_mask: assert property (s_rd_setup(ADDR_FLAGS_TWO) |=> (prdata & ~32'h10) == 32'h0)
        else $error("unimplemented second flag bits read nonzero");
    chk_clear_reads_zero: assert property (s_rd_setup(ADDR_IRQ_CLEAR) |=> prdata == 32'h0)
        else $error("clear register reads nonzero");
    chk_conv_sets_flag: assert property (conv_done_evt ##1 s_rd_setup(ADDR_FLAGS_ONE) |=> prdata[BIT_CONV_DONE])
        else $error("conversion event did not set its flag");
    chk_master_gates_irq: assert property (s_master_off |-> ##2 !irq [*2])
        else $error("interrupt with master enable off");
endmodule : pifl_irq_flags_chk

bind pifl_irq_flags pifl_irq_flags_chk u_pifl_irq_flags_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .conv_done_evt(conv_done_evt), .irq(irq));

// ===== pifl_periph_model.sv
// Model of the peripherals that raise one-cycle event pulses.
module pifl_periph_model (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic [6:0]             req,
    input  wire pifl_pkg::pifl_ccmode_t mode_req,
    output logic                        conv_done_evt,
    output logic                        serial_done_evt,
    output logic                        capture_evt,
    output logic                        compare_evt,
    output logic                        period_match_evt,
    output logic                        overflow_evt,
    output logic                        nvm_write_done_evt,
    output pifl_pkg::pifl_ccmode_t      capcomp_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    import pifl_pkg::*;

    // Events leave a flop, as from real same-clock logic; mode moves with them so both land together.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {nvm_write_done_evt, overflow_evt, period_match_evt, compare_evt, capture_evt, serial_done_evt,
             conv_done_evt} <= 7'h00;
            capcomp_mode <= PIFL_CC_OFF;
        end else begin
            {nvm_write_done_evt, overflow_evt, period_match_evt, compare_evt, capture_evt, serial_done_evt,
             conv_done_evt} <= req;
            capcomp_mode <= mode_req;
        end
    end
endmodule : pifl_periph_model

// ===== tb_top.sv
// Self-checking testbench of the peripheral interrupt flag block.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pifl_pkg::*;

    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd, seed, exp;
    logic [3:0]        pstrb;
    logic [6:0]        req;
    logic [7:0]        en;
    pifl_ccmode_t      mode_req, capcomp_mode;
    logic              conv_done_evt, serial_done_evt, capture_evt, compare_evt;
    logic              period_match_evt, overflow_evt, nvm_write_done_evt;
    int                err_total, check_count;

    // Registers read at reset.
    logic [ADDR_W-1:0] fexp_addr [7] = '{ADDR_FLAGS_ONE, ADDR_FLAGS_TWO, ADDR_ENABLES_TWO, ADDR_CORE_CTRL,
                                        ADDR_IRQ_STATUS, ADDR_IRQ_CLEAR, ADDR_IRQ_ENABLE};

    // Half period of 25 ns gives 20 MHz.
    always #25 pclk = ~pclk;

    pifl_irq_flags u_pifl_irq_flags (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .conv_done_evt(conv_done_evt), .serial_done_evt(serial_done_evt),
        .capture_evt(capture_evt), .compare_evt(compare_evt), .period_match_evt(period_match_evt),
        .overflow_evt(overflow_evt), .nvm_write_done_evt(nvm_write_done_evt), .capcomp_mode(capcomp_mode),
        .irq(irq));
    pifl_periph_model u_pifl_periph_model (.pclk(pclk), .presetn(presetn), .req(req), .mode_req(mode_req),
        .conv_done_evt(conv_done_evt), .serial_done_evt(serial_done_evt), .capture_evt(capture_evt),
        .compare_evt(compare_evt), .period_match_evt(period_match_evt), .overflow_evt(overflow_evt),
        .nvm_write_done_evt(nvm_write_done_evt), .capcomp_mode(capcomp_mode));

    // Step of the xorshift generator.
    function automatic logic [31:0] xs(logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs

    // Flags one bits that an event vector should set under a given mode.
    function automatic logic [31:0] fexp(logic [6:0] v, pifl_ccmode_t m);
        fexp = 32'h0;
        fexp[BIT_CONV_DONE] = v[0];
        fexp[BIT_SERIAL] = v[1];
        fexp[BIT_CAPCOMP] = (v[2] && m == PIFL_CC_CAPTURE) || (v[3] && m == PIFL_CC_COMPARE);
        fexp[BIT_PERIOD_MATCH] = v[4];
        fexp[BIT_OVERFLOW] = v[5];
    endfunction : fexp

    // Compare and count.
    task automatic check(string what, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : check

    // One APB transfer; entered just after an edge, ends with one idle cycle so calls never collide.
    task automatic apb(logic wr, logic [ADDR_W-1:0] a, logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Ready is sampled at rising edges only; the watchdog ends a hang.
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // Read one register and compare.
    task automatic rdc(string w, logic [ADDR_W-1:0] a, logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(w, e, rd);
    endtask : rdc

    // Ask the peripherals for one event pulse; returns so a read can follow at once.
    task automatic pulse(logic [6:0] v, pifl_ccmode_t m);
        req <= v;
        mode_req <= m;
        @(posedge pclk);
        req <= 7'h00;
        @(posedge pclk);
    endtask : pulse

    // Look at the interrupt line mid-cycle, where it is settled.
    task automatic irqc(logic e);
        @(negedge pclk);
        check("irq", {31'h0, e}, {31'h0, irq});
        @(posedge pclk);
    endtask : irqc

    // Verdict and end of run.
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out

    // Whole run is under seven hundred cycles, far inside this limit.
    initial begin
        #500us;
        err_total++;
        $display("MISMATCH watchdog expected done seen timeout");
        close_out();
    end

    // Main sequence.
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite} = 3'b000;
        paddr = '0;
        pwdata = 32'h0;
        pstrb = 4'hF;
        req = 7'h00;
        mode_req = PIFL_CC_OFF;
        seed = 32'h53B6;
        err_total = 0;
        check_count = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (fexp_addr[i]) rdc("reset value", fexp_addr[i], RST_WORD);
        apb(1'b0, 12'hFFC, 32'h0);
        check("unmapped error", 32'h1, {31'h0, err});
        check("unmapped data", 32'h0, rd);
        $display("test reset done");
        // Each event alone, enables all off; hardware never clears, software does.
        for (int i = 0; i < 6; i++) begin
            pulse(7'h01 << i, PIFL_CC_CAPTURE);
            rdc("event flag", ADDR_FLAGS_ONE, fexp(7'h01 << i, PIFL_CC_CAPTURE));
            apb(1'b1, ADDR_FLAGS_ONE, 32'h0);
        end
        pulse(7'h40, PIFL_CC_OFF);
        rdc("write done flag", ADDR_FLAGS_TWO, 32'h10);
        irqc(1'b0);
        $display("test events done");
        // Every mode against both capture/compare events.
        for (int m = 0; m < 4; m++) begin
            for (int e = 2; e < 4; e++) begin
                pulse(7'h01 << e, pifl_ccmode_t'(m));
                rdc("capcomp mode", ADDR_FLAGS_ONE, fexp(7'h01 << e, pifl_ccmode_t'(m)));
                apb(1'b1, ADDR_IRQ_CLEAR, 32'h4);
            end
        end
        $display("test modes done");
        apb(1'b1, ADDR_FLAGS_ONE, 32'hFF);
        rdc("flags one mask", ADDR_FLAGS_ONE, 32'h4F);
        apb(1'b1, ADDR_ENABLES_TWO, 32'hFF);
        rdc("enables two mask", ADDR_ENABLES_TWO, 32'h10);
        apb(1'b1, ADDR_IRQ_STATUS, 32'h0);
        rdc("status read only", ADDR_IRQ_STATUS, 32'h104F);
        apb(1'b1, ADDR_IRQ_CLEAR, 32'h104F);
        rdc("status cleared", ADDR_IRQ_STATUS, 32'h0);
        $display("test masks done");
        // Write-done interrupt through every combination of the two core enables, then its own enable and clear.
        pulse(7'h40, PIFL_CC_OFF);
        for (int g = 0; g < 4; g++) begin
            apb(1'b1, ADDR_CORE_CTRL, g << 6);
            irqc(g == 3);
        end
        apb(1'b1, ADDR_ENABLES_TWO, 32'h0);
        irqc(1'b0);
        apb(1'b1, ADDR_ENABLES_TWO, 32'h10);
        irqc(1'b1);
        pstrb <= 4'h1;
        apb(1'b1, ADDR_IRQ_CLEAR, 32'h1000);
        irqc(1'b1);
        pstrb <= 4'hF;
        apb(1'b1, ADDR_IRQ_CLEAR, 32'h1000);
        irqc(1'b0);
        $display("test interrupt done");
        // Random writes, events and enables.
        for (int k = 0; k < 40; k++) begin
            seed = xs(seed);
            en = seed[15:8] & MASK_ONE;
            apb(1'b1, ADDR_IRQ_ENABLE, {24'h0, seed[15:8]});
            apb(1'b1, ADDR_FLAGS_ONE, {24'h0, seed[7:0]});
            pulse(seed[22:16] & 7'h3F, PIFL_CC_CAPTURE);
            exp = (seed[7:0] & MASK_ONE) | fexp(seed[22:16], PIFL_CC_CAPTURE);
            rdc("random flags", ADDR_FLAGS_ONE, exp);
            irqc(|(exp[7:0] & en));
        end
        $display("test random done");
        close_out();
    end
endmodule : tb_top
